// [biphase_cfg.svh]
`ifndef BIPHASE_CFG_SVH
`define BIPHASE_CFG_SVH

// transceiver clock ticks inside one bit (clock is eight times the bit rate)
`define TICKS_PER_BIT    5'd8
`define SUB_BIT_LAST     5'd7
`define SUB_HALF         5'd4
// code violation spans three half... 1.5 bits low then 1.5 bits high
`define SUB_CV_LAST      5'd23
`define SUB_CV_HIGH      5'd12
`define QUIESCE_LAST     8'd4
`define DATA_BITS_LAST   8'd8
`define MIN_FILL_BITS    8'd3
`define END_BITS_LAST    8'd2
// oscillator scaling for the transceiver clock
`define OSC_DIV_LAST     4'd5
// receiver run length that marks half of a code violation
`define RX_CV_MIN_RUN    5'd10
`define RX_RUN_MAX       5'd31
`define RX_SAMPLE_FIRST  3'd2
`define RX_SAMPLE_SECOND 3'd6
`define RX_RESYNC_LO     3'd3
`define RX_RESYNC_HI     3'd5
`define RX_RESYNC_SUB    3'd5
`define FIFO_DEPTH       16
`define TX_ENTRY_WIDTH   9

`endif

// [biphase_pkg.sv]
package biphase_pkg;

    typedef enum logic [1:0] {
        MODE_COAX   = 2'h0,
        MODE_TWINAX = 2'h1,
        MODE_GEN8   = 2'h2
    } line_mode_t;

    typedef enum logic [5:0] {
        TX_IDLE    = 6'h01,
        TX_QUIESCE = 6'h02,
        TX_CV      = 6'h04,
        TX_FRAME   = 6'h08,
        TX_FILL    = 6'h10,
        TX_END     = 6'h20
    } tx_state_t;

    typedef enum logic [4:0] {
        RX_HUNT    = 5'h01,
        RX_CV_HIGH = 5'h02,
        RX_GAP     = 5'h04,
        RX_BITS    = 5'h08,
        RX_SPARE   = 5'h10
    } rx_state_t;

endpackage

// [tx_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // head is read through a register; consumers look at it well after push
    always_ff @(posedge core_clk) begin
        out_data <= mem[rd_ptr_reg];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

`default_nettype wire

// [biphase_line_framing.sv]
`timescale 1ns/10ps
`default_nettype none
`include "biphase_cfg.svh"

module biphase_line_framing (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire biphase_pkg::line_mode_t   line_mode,
    input  wire logic                      promiscuous,
    input  wire logic [7:0]                station_address,
    input  wire logic [7:0]                fill_bits,
    input  wire logic                      clock_select_external,
    input  wire logic                      external_line_clock,
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    input  wire logic [7:0]                tx_data,
    input  wire logic                      tx_last,
    output logic                           tx_line,
    output logic                           tx_line_oe,
    output logic                           tx_busy,
    input  wire logic                      rx_line,
    output logic [7:0]                     rx_data,
    output logic                           rx_address_frame,
    output logic                           data_available,
    output logic                           rx_message_end,
    output logic                           rx_error
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic biphase_level(input logic bit_value,
                                           input logic second_half,
                                           input logic reversed);
        biphase_level = (second_half ? bit_value : ~bit_value) ^ reversed;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // transceiver clock enable
    logic [3:0] osc_div_reg;
    logic       ext_prev_reg;
    logic       osc_tick;
    logic       transceiver_clock_en;
    logic       twinax;

    assign twinax   = (line_mode == biphase_pkg::MODE_TWINAX);
    assign osc_tick = (osc_div_reg == `OSC_DIV_LAST);
    assign transceiver_clock_en  = clock_select_external
                      ? (external_line_clock && !ext_prev_reg)
                      : osc_tick;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            osc_div_reg <= 4'h0;
        end else if (osc_tick) begin
            osc_div_reg <= 4'h0;
        end else begin
            osc_div_reg <= osc_div_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= external_line_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit path
    biphase_pkg::tx_state_t tx_state_reg;
    logic [4:0]  tx_sub_reg;
    logic [7:0]  tx_bit_reg;
    logic [8:0]  tx_shift_reg;
    logic        tx_last_reg;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [`TX_ENTRY_WIDTH-1:0] fifo_data;
    logic [4:0]  tx_sub_last;
    logic        bit_done;
    logic        need_frame;
    logic [7:0]  fill_last;
    logic        tx_level;
    logic        second_half;

    // back-pressure from the fifo reaches the byte source
    tx_fifo #(
        .WIDTH (`TX_ENTRY_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   ({tx_last, tx_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign tx_sub_last = (tx_state_reg == biphase_pkg::TX_CV)
                         ? `SUB_CV_LAST : `SUB_BIT_LAST;
    assign bit_done    = transceiver_clock_en && (tx_state_reg != biphase_pkg::TX_IDLE)
                         && (tx_sub_reg == tx_sub_last);
    assign fill_last   = ((fill_bits > `MIN_FILL_BITS) ? fill_bits
                          : `MIN_FILL_BITS) - 8'h1;
    assign need_frame  = bit_done && (
        (tx_state_reg == biphase_pkg::TX_CV) ||
        (tx_state_reg == biphase_pkg::TX_FILL && tx_bit_reg == fill_last) ||
        (tx_state_reg == biphase_pkg::TX_FRAME &&
         tx_bit_reg == `DATA_BITS_LAST && !tx_last_reg && !twinax));
    assign fifo_pop    = need_frame && fifo_valid;
    assign second_half = (tx_sub_reg >= `SUB_HALF);

    always_comb begin
        unique case (tx_state_reg)
            biphase_pkg::TX_IDLE:    tx_level = 1'b0;
            biphase_pkg::TX_QUIESCE: tx_level = biphase_level(1'b1,
                                         second_half, twinax);
            biphase_pkg::TX_CV:      tx_level = (tx_sub_reg >= `SUB_CV_HIGH)
                                         ^ twinax;
            biphase_pkg::TX_FRAME:   tx_level = biphase_level(
                                         tx_shift_reg[0], second_half,
                                         twinax);
            biphase_pkg::TX_FILL:    tx_level = biphase_level(1'b0,
                                         second_half, twinax);
            biphase_pkg::TX_END: begin
                // twinax ends on plain fill bits, never a mini violation
                if (twinax || tx_bit_reg == 8'h0) begin
                    tx_level = biphase_level(1'b0, second_half, twinax);
                end else begin
                    tx_level = 1'b1;
                end
            end
            default:                 tx_level = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_state_reg <= biphase_pkg::TX_IDLE;
            tx_sub_reg   <= 5'h0;
            tx_bit_reg   <= 8'h0;
            tx_shift_reg <= 9'h0;
            tx_last_reg  <= 1'b0;
        end else if (transceiver_clock_en) begin
            if (tx_state_reg == biphase_pkg::TX_IDLE) begin
                if (fifo_valid) begin
                    tx_state_reg <= biphase_pkg::TX_QUIESCE;
                    tx_sub_reg   <= 5'h0;
                    tx_bit_reg   <= 8'h0;
                end
            end else if (!bit_done) begin
                tx_sub_reg <= tx_sub_reg + 5'h1;
            end else begin
                tx_sub_reg <= 5'h0;
                tx_bit_reg <= tx_bit_reg + 8'h1;
                if (need_frame) begin
                    tx_bit_reg <= 8'h0;
                    if (fifo_valid) begin
                        tx_state_reg <= biphase_pkg::TX_FRAME;
                        tx_shift_reg <= {fifo_data[7:0], 1'b1};
                        tx_last_reg  <= fifo_data[8];
                    end else begin
                        // source ran dry: close the message cleanly
                        tx_state_reg <= biphase_pkg::TX_END;
                    end
                end else begin
                    unique case (tx_state_reg)
                        biphase_pkg::TX_QUIESCE: begin
                            if (tx_bit_reg == `QUIESCE_LAST) begin
                                tx_state_reg <= biphase_pkg::TX_CV;
                                tx_bit_reg   <= 8'h0;
                            end
                        end
                        biphase_pkg::TX_FRAME: begin
                            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                            if (tx_bit_reg == `DATA_BITS_LAST) begin
                                tx_bit_reg   <= 8'h0;
                                tx_state_reg <= tx_last_reg
                                    ? biphase_pkg::TX_END
                                    : biphase_pkg::TX_FILL;
                            end
                        end
                        biphase_pkg::TX_END: begin
                            if (tx_bit_reg == `END_BITS_LAST) begin
                                tx_state_reg <= biphase_pkg::TX_IDLE;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_line    <= 1'b0;
            tx_line_oe <= 1'b0;
        end else if (transceiver_clock_en) begin
            tx_line    <= tx_level;
            tx_line_oe <= (tx_state_reg != biphase_pkg::TX_IDLE);
        end
    end

    assign tx_busy = (tx_state_reg != biphase_pkg::TX_IDLE) || tx_line_oe;

    ////////////////////////////////////////////////////////////////////////
    // receive path
    biphase_pkg::rx_state_t rx_state_reg;
    logic       rx_prev_reg;
    logic [4:0] rx_run_reg;
    logic [2:0] rx_sub_reg;
    logic       rx_first_half_reg;
    logic [7:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic       rx_addr_pending_reg;
    logic       rx_accept_reg;
    logic       rx_norm;
    logic       rx_edge;
    logic       rx_eval;
    logic       rx_violation;
    logic       accept_all;
    logic [7:0] rx_byte;

    assign rx_norm      = rx_line ^ twinax;
    assign rx_edge      = (rx_norm != rx_prev_reg);
    assign rx_eval      = transceiver_clock_en && (rx_sub_reg == `RX_SAMPLE_SECOND);
    assign rx_violation = (rx_first_half_reg == rx_norm);
    assign rx_byte      = {rx_norm, rx_shift_reg[7:1]};
    // coax has no address frame filtering
    assign accept_all   = promiscuous
                          || (line_mode == biphase_pkg::MODE_COAX);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_prev_reg <= 1'b0;
            rx_run_reg  <= 5'h0;
        end else if (transceiver_clock_en) begin
            rx_prev_reg <= rx_norm;
            if (rx_edge) begin
                rx_run_reg <= 5'h1;
            end else if (rx_run_reg != `RX_RUN_MAX) begin
                rx_run_reg <= rx_run_reg + 5'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_sub_reg        <= 3'h0;
            rx_first_half_reg <= 1'b0;
        end else if (transceiver_clock_en) begin
            if (rx_state_reg == biphase_pkg::RX_CV_HIGH && rx_edge) begin
                rx_sub_reg <= 3'h1;
            end else if (rx_edge && rx_sub_reg >= `RX_RESYNC_LO
                         && rx_sub_reg <= `RX_RESYNC_HI) begin
                // track the sender on every mid-bit edge
                rx_sub_reg <= `RX_RESYNC_SUB;
            end else begin
                rx_sub_reg <= rx_sub_reg + 3'h1;
            end
            if (rx_sub_reg == `RX_SAMPLE_FIRST) begin
                rx_first_half_reg <= rx_norm;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_state_reg <= biphase_pkg::RX_HUNT;
            rx_bit_reg   <= 8'h0;
            rx_shift_reg <= 8'h0;
        end else if (transceiver_clock_en) begin
            unique case (rx_state_reg)
                biphase_pkg::RX_HUNT: begin
                    // low half of the code violation, then its high half
                    if (rx_edge && rx_norm
                        && rx_run_reg >= `RX_CV_MIN_RUN) begin
                        rx_state_reg <= biphase_pkg::RX_CV_HIGH;
                    end
                end
                biphase_pkg::RX_CV_HIGH: begin
                    if (rx_edge) begin
                        rx_state_reg <= (rx_run_reg >= `RX_CV_MIN_RUN)
                            ? biphase_pkg::RX_GAP
                            : biphase_pkg::RX_HUNT;
                    end
                end
                biphase_pkg::RX_GAP: begin
                    if (rx_sub_reg == `RX_SAMPLE_SECOND) begin
                        if (rx_violation) begin
                            rx_state_reg <= biphase_pkg::RX_HUNT;
                        end else if (rx_norm) begin
                            rx_state_reg <= biphase_pkg::RX_BITS;
                            rx_bit_reg   <= 8'h0;
                        end else if (!twinax) begin
                            rx_state_reg <= biphase_pkg::RX_HUNT;
                        end
                    end
                end
                biphase_pkg::RX_BITS: begin
                    if (rx_sub_reg == `RX_SAMPLE_SECOND) begin
                        rx_shift_reg <= rx_byte;
                        rx_bit_reg   <= rx_bit_reg + 8'h1;
                        if (rx_violation) begin
                            rx_state_reg <= biphase_pkg::RX_HUNT;
                        end else if (rx_bit_reg == `DATA_BITS_LAST - 8'h1)
                        begin
                            rx_state_reg <= biphase_pkg::RX_GAP;
                        end
                    end
                end
                default: begin
                    rx_state_reg <= biphase_pkg::RX_HUNT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received bytes, address filter and status pulses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_data             <= 8'h0;
            rx_address_frame    <= 1'b0;
            data_available      <= 1'b0;
            rx_message_end      <= 1'b0;
            rx_error            <= 1'b0;
            rx_addr_pending_reg <= 1'b0;
            rx_accept_reg       <= 1'b0;
        end else begin
            data_available <= 1'b0;
            rx_message_end <= 1'b0;
            rx_error       <= 1'b0;
            if (transceiver_clock_en && rx_state_reg == biphase_pkg::RX_CV_HIGH) begin
                rx_addr_pending_reg <= 1'b1;
            end
            if (rx_eval && rx_state_reg == biphase_pkg::RX_BITS) begin
                if (rx_violation) begin
                    rx_error <= 1'b1;
                end else if (rx_bit_reg == `DATA_BITS_LAST - 8'h1) begin
                    rx_data             <= rx_byte;
                    rx_address_frame    <= rx_addr_pending_reg;
                    rx_addr_pending_reg <= 1'b0;
                    if (rx_addr_pending_reg) begin
                        rx_accept_reg  <= accept_all
                            || (rx_byte == station_address);
                        data_available <= accept_all
                            || (rx_byte == station_address);
                    end else begin
                        data_available <= rx_accept_reg;
                    end
                end
            end
            if (rx_eval && rx_state_reg == biphase_pkg::RX_GAP
                && (rx_violation || (!rx_norm && !twinax))) begin
                rx_message_end <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [biphase_line_framing_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module biphase_line_framing_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clock_select_external,
    input wire logic tx_ready,
    input wire logic tx_line,
    input wire logic tx_line_oe,
    input wire logic tx_busy,
    input wire logic data_available,
    input wire logic rx_message_end,
    input wire logic rx_error
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic       line_d_reg;
    logic [7:0] run_reg;
    ////////////////////////////////////////
    // run length of one driven level, saturating
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) line_d_reg <= 1'b0;
        else line_d_reg <= tx_line;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) run_reg <= 8'h00;
        else if (!tx_line_oe || tx_line != line_d_reg) run_reg <= 8'h00;
        else if (run_reg != 8'hff) run_reg <= run_reg + 8'h01;
    end
    ////////////////////////////////////////
    reset_quiet_a: assert property (disable iff (1'b0)
        rst |-> !tx_line_oe && !tx_line && tx_ready) else $error("reset");
    idle_low_a: assert property (!tx_line_oe |-> !tx_line)
        else $error("line not low when idle");
    oe_busy_a: assert property ($rose(tx_busy) |-> ##6 tx_line_oe)
        else $error("late drive after busy");
    // half bits are four ticks of six cycles on the oscillator tick
    tick_hold_a: assert property (tx_line_oe && !clock_select_external
        && $changed(tx_line) |=> $stable(tx_line)[*5])
        else $error("line changed between ticks");
    run_limit_a: assert property (tx_line_oe && !clock_select_external
        |-> run_reg <= (tx_line ? 8'd100 : 8'd76)) else $error("run long");
    avail_pulse_a: assert property (data_available |=> !data_available)
        else $error("data pulse too long");
    end_pulse_a: assert property (rx_message_end |=> !rx_message_end)
        else $error("end pulse too long");
    err_pulse_a: assert property (rx_error |=> !rx_error)
        else $error("error pulse too long");
    err_excl_a: assert property (rx_error |-> !data_available)
        else $error("data with error");
    cover property (data_available);
    cover property (rx_error);
    cover property (!tx_ready);
endmodule
bind biphase_line_framing biphase_line_framing_chk u_biphase_line_framing_chk (
    .core_clk(core_clk), .rst(rst), .tx_ready(tx_ready),
    .clock_select_external(clock_select_external), .tx_line(tx_line),
    .tx_line_oe(tx_line_oe), .tx_busy(tx_busy), .rx_error(rx_error),
    .data_available(data_available), .rx_message_end(rx_message_end));
`default_nettype wire

// [remote_station_model.sv]
`timescale 1ns/10ps
`default_nettype none
module remote_station_model (
    input  wire logic core_clk,
    output var logic  line
);
    logic inv;
    initial line = 1'b0;
    ////////////////////////////////////////
    task automatic half(input logic lvl);
        line = lvl ^ inv;
        repeat (24) @(negedge core_clk);
    endtask
    task automatic bit_out(input logic b);
        half(!b);
        half(b);
    endtask
    task automatic send_msg(input biphase_pkg::line_mode_t mode,
                            input logic [7:0] d0, input logic [7:0] d1,
                            input logic bad);
        logic [7:0] d;
        inv = (mode == biphase_pkg::MODE_TWINAX);
        @(negedge core_clk);
        repeat (5) bit_out(1'b1);
        repeat (3) half(1'b0);
        repeat (3) half(1'b1);
        for (int f = 0; f < 2; f++) begin
            d = f ? d1 : d0;
            bit_out(1'b1);
            for (int i = 0; i < 8; i++) begin
                if (bad && f == 1 && i == 3) begin
                    half(d[i]);
                    half(d[i]);
                end else bit_out(d[i]);
            end
            if (inv && f == 0) repeat (3) bit_out(1'b0);
        end
        if (inv) repeat (3) bit_out(1'b0);
        else begin
            bit_out(1'b0);
            repeat (4) half(1'b1);
        end
        // released: plain low in every mode, no twinax inversion applied
        line = 1'b0;
    endtask
endmodule
`default_nettype wire

// [biphase_line_framing_test.sv]
`timescale 1ns/10ps
`default_nettype none
module biphase_line_framing_test;
    logic       core_clk = 1'b0, rst = 1'b0, inv_r, full_seen;
    logic       promiscuous = 1'b0, clock_select_external = 1'b0;
    logic       external_line_clock = 1'b0, ext_on = 1'b0;
    logic       tx_valid = 1'b0, tx_last = 1'b0;
    logic [7:0] station_address = 8'h42, fill_bits = 8'h01, tx_data = 8'h00;
    biphase_pkg::line_mode_t line_mode = biphase_pkg::MODE_COAX;
    wire logic  tx_ready, tx_line, tx_line_oe, tx_busy, rx_line;
    wire logic  rx_address_frame, data_available, rx_message_end, rx_error;
    wire logic [7:0] rx_data;
    logic [7:0] addr_got;
    int         miscompares = 0, samples_checked = 0, da_cnt, end_cnt, err_cnt;
    logic       exp_q[$];
    biphase_line_framing u_biphase_line_framing (
        .core_clk, .rst, .line_mode, .promiscuous, .station_address,
        .fill_bits, .clock_select_external, .external_line_clock,
        .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_line, .tx_line_oe,
        .tx_busy, .rx_line, .rx_data, .rx_address_frame, .data_available,
        .rx_message_end, .rx_error);
    remote_station_model u_remote_station_model (.core_clk(core_clk),
                                                 .line(rx_line));
    initial forever #10 core_clk = ~core_clk;
    // six-cycle external tick
    always #60 external_line_clock = ext_on & ~external_line_clock;
    always @(posedge core_clk) begin
        if (data_available === 1'b1) da_cnt++;
        if (rx_message_end === 1'b1) end_cnt++;
        if (rx_error === 1'b1) err_cnt++;
        if (rx_address_frame === 1'b1) addr_got = rx_data;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic give_up(input string what);
        chk(8'h00, 8'h01, what);
        print_verdict();
    endtask
    task automatic add_half(input logic lvl);
        exp_q.push_back(lvl ^ inv_r);
    endtask
    task automatic add_bit(input logic b);
        add_half(!b);
        add_half(b);
    endtask
    task automatic tx_msg(input biphase_pkg::line_mode_t mode, input int n,
                          input logic [7:0] base);
        int w;
        int fills;
        logic [7:0] d;
        exp_q.delete();
        inv_r = (mode == biphase_pkg::MODE_TWINAX);
        fills = (fill_bits < 8'd3) ? 3 : int'(fill_bits);
        line_mode = mode;
        full_seen = 1'b0;
        repeat (5) add_bit(1'b1);
        repeat (3) add_half(1'b0);
        repeat (3) add_half(1'b1);
        for (int i = 0; i < n; i++) begin
            d = base + 8'(i);
            add_bit(1'b1);
            for (int j = 0; j < 8; j++) add_bit(d[j]);
            if (inv_r && i < n - 1) repeat (fills) add_bit(1'b0);
        end
        if (inv_r) repeat (3) add_bit(1'b0);
        else begin
            add_bit(1'b0);
            repeat (4) add_half(1'b1);
        end
        fork
            begin
                for (int i = 0; i < n; i++) begin
                    tx_valid = 1'b1;
                    tx_data = base + 8'(i);
                    tx_last = (i == n - 1);
                    for (int v = 0; tx_ready !== 1'b1; v++) begin
                        if (v == 5000) give_up("push");
                        full_seen = 1'b1;
                        @(negedge core_clk);
                    end
                    @(negedge core_clk);
                end
                tx_valid = 1'b0;
                tx_last = 1'b0;
            end
            begin
                for (w = 0; tx_line_oe !== 1'b1; w++) begin
                    if (w == 3000) give_up("no drive");
                    @(negedge core_clk);
                end
                // mid-half sampling tolerates the one-tick line lag
                repeat (14) @(negedge core_clk);
                foreach (exp_q[k]) begin
                    chk(tx_line, exp_q[k], "line half");
                    chk(tx_line_oe, 1'b1, "drive");
                    repeat (24) @(negedge core_clk);
                end
            end
        join
        for (w = 0; tx_line_oe !== 1'b0; w++) begin
            if (w == 40) give_up("drive held");
            @(negedge core_clk);
        end
        chk(tx_line, 1'b0, "idle line");
    endtask
    task automatic rx_msg(input biphase_pkg::line_mode_t mode,
                          input logic prom, input logic [7:0] addr,
                          input logic bad, input int exp_da);
        line_mode = mode;
        promiscuous = prom;
        da_cnt = 0;
        end_cnt = 0;
        err_cnt = 0;
        addr_got = 8'h00;
        u_remote_station_model.send_msg(mode, addr, 8'hc6, bad);
        repeat (200) @(negedge core_clk);
        chk(8'(da_cnt), 8'(exp_da), "data pulses");
        chk(8'(err_cnt), {7'h00, bad}, "errors");
        if (!bad) chk(8'(end_cnt), 8'h01, "ends");
        if (!bad) chk(rx_data, 8'hc6, "rx byte");
        chk(addr_got, addr, "address");
    endtask
    ////////////////////////////////////////
    initial begin
        #1 rst = 1'b1;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        tx_msg(biphase_pkg::MODE_COAX, 2, 8'ha5);
        tx_msg(biphase_pkg::MODE_TWINAX, 2, 8'h3c);
        fill_bits = 8'h05;
        tx_msg(biphase_pkg::MODE_TWINAX, 2, 8'h96);
        tx_msg(biphase_pkg::MODE_GEN8, 1, 8'h81);
        tx_msg(biphase_pkg::MODE_COAX, 20, 8'h30);
        chk(full_seen, 1'b1, "fifo full");
        rx_msg(biphase_pkg::MODE_COAX, 1'b0, 8'h17, 1'b0, 2);
        rx_msg(biphase_pkg::MODE_TWINAX, 1'b0, 8'h42, 1'b0, 2);
        rx_msg(biphase_pkg::MODE_TWINAX, 1'b0, 8'h17, 1'b0, 0);
        rx_msg(biphase_pkg::MODE_TWINAX, 1'b1, 8'h17, 1'b0, 2);
        rx_msg(biphase_pkg::MODE_GEN8, 1'b0, 8'h17, 1'b0, 0);
        rx_msg(biphase_pkg::MODE_GEN8, 1'b1, 8'h17, 1'b0, 2);
        rx_msg(biphase_pkg::MODE_COAX, 1'b1, 8'h17, 1'b1, 1);
        ext_on = 1'b1;
        clock_select_external = 1'b1;
        rx_msg(biphase_pkg::MODE_GEN8, 1'b0, 8'h42, 1'b0, 2);
        tx_msg(biphase_pkg::MODE_COAX, 1, 8'h5e);
        print_verdict();
    end
endmodule
`default_nettype wire
